// ---- verilog/accel_event_pkg.sv ----
package accel_event_pkg;

  // Register offsets.
  localparam logic [6:0] OFF_AXIS_ENABLE    = 7'h20;
  localparam logic [6:0] OFF_PAD_CONTROL    = 7'h22;
  localparam logic [6:0] OFF_SAMPLE_STATUS  = 7'h27;
  localparam logic [6:0] OFF_X_SAMPLE       = 7'h29;
  localparam logic [6:0] OFF_Y_SAMPLE       = 7'h2b;
  localparam logic [6:0] OFF_Z_SAMPLE       = 7'h2d;
  localparam logic [6:0] OFF_EVENT_CONFIG   = 7'h30;
  localparam logic [6:0] OFF_EVENT_SOURCE   = 7'h31;
  localparam logic [6:0] OFF_EVENT_THRESH   = 7'h32;
  localparam logic [6:0] OFF_EVENT_DURATION = 7'h33;

  // Reset values.
  localparam logic [7:0] RST_AXIS_ENABLE    = 8'h07;
  localparam logic [7:0] RST_PAD_CONTROL    = 8'h00;
  localparam logic [7:0] RST_EVENT_CONFIG   = 8'h00;
  localparam logic [7:0] RST_EVENT_THRESH   = 8'h02;
  localparam logic [7:0] RST_EVENT_DURATION = 8'h00;

  // Field positions.
  localparam int POS_PAD_POLARITY_LOW = 7;
  localparam int POS_COMBINE_ALL      = 7;
  localparam int POS_LATCH_REQUEST    = 6;
  localparam int POS_DECREMENT_MODE   = 7;
  localparam int POS_ALL_OVERRUN      = 7;
  localparam int POS_ALL_NEW_DATA     = 3;
  localparam int POS_REQUEST_ACTIVE   = 6;

  // Pad source selector codes.
  localparam logic [2:0] PAD_SRC_GROUND = 3'h0;
  localparam logic [2:0] PAD_SRC_MOTION = 3'h1;
  localparam logic [2:0] PAD_SRC_READY  = 3'h4;

  // Duration steps: one output data period.
  localparam real STEP_FAST_MS = 2.5;
  localparam real STEP_SLOW_MS = 10.0;

endpackage

// ---- verilog/axis_flags.sv ----
`timescale 1ns/1ps
// New-data and overrun flags for one axis; a new sample wins over a read for new-data, while a read clears overrun.
module axis_flags (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Events
  input  wire logic       enable_in,
  input  wire logic       sample_in,
  input  wire logic       read_in,
  // Flags
  output logic            new_data_out,
  output logic            overrun_out
);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      new_data_out <= 1'b0;
    end else if (sample_in && enable_in) begin
      new_data_out <= 1'b1;                                  // [RULE_08]
    end else if (read_in) begin
      new_data_out <= 1'b0;                                  // [RULE_20]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overrun_out <= 1'b0;
    end else if (sample_in && enable_in && new_data_out && !read_in) begin
      overrun_out <= 1'b1;                                   // [RULE_06]
    end else if (read_in) begin
      overrun_out <= 1'b0;                                   // [RULE_20]
    end
  end

endmodule

// ---- verilog/event_duration.sv ----
`timescale 1ns/1ps
// Duration counter ticking once per output data period.
module event_duration #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Control
  input  wire logic             tick_in,
  input  wire logic             condition_in,
  input  wire logic             decrement_in,
  input  wire logic             freeze_in,
  input  wire logic [WIDTH-1:0] limit_in,
  // Result
  output logic                  expired_out
);

  logic [WIDTH-1:0] count_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else if (freeze_in) begin
      count_q <= count_q;                                    // [RULE_18]
    end else if (tick_in) begin
      if (condition_in) begin
        if (count_q != limit_in) begin
          count_q <= count_q + WIDTH'(1);                    // [RULE_18]
        end
      end else if (decrement_in) begin
        if (count_q != '0) begin
          count_q <= count_q - WIDTH'(1);                    // [RULE_17]
        end
      end else begin
        count_q <= '0;                                       // [RULE_17]
      end
    end
  end

  assign expired_out = condition_in && (count_q >= limit_in);

endmodule

// ---- verilog/accel_event_regs.sv ----
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Polarity bit zero drives pad high
// [RULE_02] Selector picks ground, motion event, or ready
// [RULE_03] Host uses only the three selector codes
// [RULE_04] Host keeps control bits six to three zero
// [RULE_05] Combined overrun on unread full set
// [RULE_06] Per-axis overrun on unread sample replaced
// [RULE_07] Combined new-data when full set ready
// [RULE_08] Per-axis new-data on fresh sample
// [RULE_09] Status layout: overruns high, new-data low
// [RULE_10] Samples are signed eight-bit values
// [RULE_11] Combination bit selects OR versus AND
// [RULE_12] Latch holds request until source read
// [RULE_13] Above-threshold enables per axis
// [RULE_14] Below-threshold enables per axis
// [RULE_15] Event configuration bit layout
// [RULE_16] Source read clears request and latch
// [RULE_17] Seven-bit threshold; top bit selects decrement
// [RULE_18] Duration steps per data period, frozen when latched
// [RULE_19] New-data only for enabled axes
// [RULE_20] Sample read clears that axis' flags
// [RULE_21] Ready routing follows combined new-data
module accel_event_regs #(
  parameter int SAMPLE_W = 8
) (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                resetn_in,
  // Register port
  input  wire logic [6:0]          addr_in,
  input  wire logic [7:0]          wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [7:0]          rdata_out,
  // Sensing chain
  input  wire logic [SAMPLE_W-1:0] x_value_in,
  input  wire logic [SAMPLE_W-1:0] y_value_in,
  input  wire logic [SAMPLE_W-1:0] z_value_in,
  input  wire logic [2:0]          sample_valid_in,
  input  wire logic                period_tick_in,
  // Event pad
  output logic                     event_pad_out
);

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic [7:0] axis_enable_q;
  logic [7:0] pad_control_q;
  logic [7:0] event_config_q;
  logic [7:0] event_thresh_q;
  logic [7:0] event_duration_q;
  logic [7:0] sample_q [3];
  logic [7:0] source_q;
  logic       all_new_data_q;
  logic       all_overrun_q;
  logic [2:0] set_seen_q;
  logic [2:0] new_data;
  logic [2:0] overrun;
  logic [2:0] axis_read;
  logic [5:0] raw_events;
  logic [5:0] enabled_events;
  logic       condition;
  logic       expired;
  logic       latched;
  logic       request;
  logic       source_read;
  logic [2:0] fresh;
  logic       set_done;
  logic       last_read;
  logic       freeze;
  logic       decrement;
  logic       pad_level;
  logic [7:0] status;
  logic [7:0] rdata_d;

  // Reset is asserted at once but released through two flops.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Software-written configuration.
  // Reserved control bits are stored as written; keeping them clear is
  // left to the host.
  always_ff @(posedge mclk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      axis_enable_q    <= accel_event_pkg::RST_AXIS_ENABLE;  // [RULE_19]
      pad_control_q    <= accel_event_pkg::RST_PAD_CONTROL;
      event_config_q   <= accel_event_pkg::RST_EVENT_CONFIG;
      event_thresh_q   <= accel_event_pkg::RST_EVENT_THRESH; // [RULE_17]
      event_duration_q <= accel_event_pkg::RST_EVENT_DURATION;
    end else if (wr_in) begin
      if (addr_in == accel_event_pkg::OFF_AXIS_ENABLE) begin
        axis_enable_q <= wdata_in;
      end else if (addr_in == accel_event_pkg::OFF_PAD_CONTROL) begin
        pad_control_q <= wdata_in;
      end else if (addr_in == accel_event_pkg::OFF_EVENT_CONFIG) begin
        event_config_q <= wdata_in;                          // [RULE_15]
      end else if (addr_in == accel_event_pkg::OFF_EVENT_THRESH) begin
        event_thresh_q <= wdata_in;
      end else if (addr_in == accel_event_pkg::OFF_EVENT_DURATION) begin
        event_duration_q <= wdata_in;
      end
    end
  end

  assign axis_read[0] = rd_in && (addr_in == accel_event_pkg::OFF_X_SAMPLE);
  assign axis_read[1] = rd_in && (addr_in == accel_event_pkg::OFF_Y_SAMPLE);
  assign axis_read[2] = rd_in && (addr_in == accel_event_pkg::OFF_Z_SAMPLE);
  assign source_read  = rd_in &&
                        (addr_in == accel_event_pkg::OFF_EVENT_SOURCE);

  // Per-axis sample capture, flags and threshold comparison.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic [SAMPLE_W-1:0] value;
      logic [7:0]          mag;
      logic [7:0]          thr;
      assign value = (g == 0) ? x_value_in :
                     (g == 1) ? y_value_in : z_value_in;

      always_ff @(posedge mclk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
          sample_q[g] <= 8'h00;
        end else if (sample_valid_in[g]) begin
          sample_q[g] <= value[SAMPLE_W-1 -: 8];             // [RULE_10]
        end
      end

      axis_flags u_flags (
        .clk_in       (mclk_in),
        .rst_n_in     (rst_sync_q),
        .enable_in    (axis_enable_q[g]),                    // [RULE_19]
        .sample_in    (sample_valid_in[g]),
        .read_in      (axis_read[g]),
        .new_data_out (new_data[g]),
        .overrun_out  (overrun[g])
      );

      // Magnitude of the signed sample against a seven-bit threshold.
      assign mag = sample_q[g][7] ? (8'h00 - sample_q[g]) : sample_q[g];
      assign thr = {1'b0, event_thresh_q[6:0]};
      assign raw_events[2*g+1] = (mag > thr);                // [RULE_13]
      assign raw_events[2*g]   = (mag < thr);                // [RULE_14]
    end
  endgenerate

  // A set is complete once every enabled axis has delivered since the
  // last set; a disabled axis is simply left out of the set.
  assign fresh     = sample_valid_in & axis_enable_q[2:0];
  assign set_done  = ((set_seen_q | fresh) == axis_enable_q[2:0]) &&
                     (axis_enable_q[2:0] != 3'h0) && (fresh != 3'h0);
  // The combined flags drop with the read that clears the last
  // per-axis new-data flag.
  assign last_read = ((new_data & ~axis_read) == 3'h0) &&
                     (axis_read != 3'h0);

  // Combined flags track a full set of the enabled axes.
  always_ff @(posedge mclk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      set_seen_q     <= 3'h0;
      all_new_data_q <= 1'b0;
      all_overrun_q  <= 1'b0;
    end else begin
      if (set_done) begin
        set_seen_q     <= 3'h0;
        all_new_data_q <= 1'b1;                              // [RULE_07]
        if (all_new_data_q && new_data != 3'h0) begin
          all_overrun_q <= 1'b1;                             // [RULE_05]
        end
      end else begin
        set_seen_q <= set_seen_q | fresh;
        if (last_read) begin
          all_new_data_q <= 1'b0;                            // [RULE_20]
          all_overrun_q  <= 1'b0;                            // [RULE_20]
        end
      end
    end
  end

  assign status = {all_overrun_q, overrun[2], overrun[1], overrun[0],
                   all_new_data_q, new_data[2], new_data[1],
                   new_data[0]};                             // [RULE_09]

  // Motion event combination.
  assign enabled_events = raw_events & event_config_q[5:0];
  always_comb begin
    if (event_config_q[accel_event_pkg::POS_COMBINE_ALL]) begin
      condition = (event_config_q[5:0] != 6'h00) &&
                  (enabled_events == event_config_q[5:0]); // [RULE_11]
    end else begin
      condition = (enabled_events != 6'h00);                 // [RULE_11]
    end
  end

  assign latched = event_config_q[accel_event_pkg::POS_LATCH_REQUEST];
  // The duration count holds while a latched request waits for the host,
  // so the count seen after the read is the one left at the event.
  assign freeze    = latched && request;
  assign decrement = event_thresh_q[accel_event_pkg::POS_DECREMENT_MODE];

  event_duration #(
    .WIDTH (8)
  ) u_duration (
    .clk_in       (mclk_in),
    .rst_n_in     (rst_sync_q),
    .tick_in      (period_tick_in),
    .condition_in (condition),
    .decrement_in (decrement),
    .freeze_in    (freeze),
    .limit_in     (event_duration_q),
    .expired_out  (expired)
  );

  // Event source: latched until read, or live.
  // In live mode the register is rewritten every cycle, so a read has
  // nothing to clear there.
  always_ff @(posedge mclk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      source_q <= 8'h00;
    end else if (latched) begin
      if (expired) begin
        source_q <= source_q | {1'b0, 1'b1, enabled_events}; // [RULE_12]
      end else if (source_read) begin
        source_q <= 8'h00;                                   // [RULE_16]
      end
    end else begin
      source_q <= {1'b0, expired, enabled_events};           // [RULE_12]
    end
  end

  assign request = source_q[accel_event_pkg::POS_REQUEST_ACTIVE];

  always_comb begin
    case (pad_control_q[2:0])
      accel_event_pkg::PAD_SRC_MOTION: pad_level = request;  // [RULE_02]
      accel_event_pkg::PAD_SRC_READY:  pad_level = all_new_data_q; // [RULE_21]
      default:                         pad_level = 1'b0;     // [RULE_02]
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      event_pad_out <= 1'b0;
    end else if (pad_control_q[2:0] == accel_event_pkg::PAD_SRC_GROUND) begin
      // Code zero ties the pad low whatever the polarity bit says.
      event_pad_out <= 1'b0;                                 // [RULE_02]
    end else begin
      event_pad_out <= pad_level ^
        pad_control_q[accel_event_pkg::POS_PAD_POLARITY_LOW]; // [RULE_01]
    end
  end

  // Read data decode; unmapped addresses read zero.
  always_comb begin
    if (addr_in == accel_event_pkg::OFF_AXIS_ENABLE) begin
      rdata_d = axis_enable_q;
    end else if (addr_in == accel_event_pkg::OFF_PAD_CONTROL) begin
      rdata_d = pad_control_q;
    end else if (addr_in == accel_event_pkg::OFF_SAMPLE_STATUS) begin
      rdata_d = status;
    end else if (addr_in == accel_event_pkg::OFF_X_SAMPLE) begin
      rdata_d = sample_q[0];
    end else if (addr_in == accel_event_pkg::OFF_Y_SAMPLE) begin
      rdata_d = sample_q[1];
    end else if (addr_in == accel_event_pkg::OFF_Z_SAMPLE) begin
      rdata_d = sample_q[2];
    end else if (addr_in == accel_event_pkg::OFF_EVENT_CONFIG) begin
      rdata_d = event_config_q;
    end else if (addr_in == accel_event_pkg::OFF_EVENT_SOURCE) begin
      rdata_d = source_q;
    end else if (addr_in == accel_event_pkg::OFF_EVENT_THRESH) begin
      rdata_d = event_thresh_q;
    end else if (addr_in == accel_event_pkg::OFF_EVENT_DURATION) begin
      rdata_d = event_duration_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      // Outside the answer cycle the data return to zero, so a stale
      // value can never pass for a fresh one.
      rdata_out <= rdata_d;
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
// Host side of the register port; every strobe lasts one cycle.
module host_model (
  // Clock
  input  wire logic       mclk_in,
  // Register port
  output logic      [6:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in
);
  initial begin
    addr_out = 7'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    // Pad control keeps bits 6:3 clear; callers give legal codes only.
    v = (a == 7'h22) ? (d & 8'h87) : d;
    @(posedge mclk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge mclk_in);
    wr_out <= 1'b0;
    // Released data shows the inverse so stale values cannot pass.
    wdata_out <= ~v;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    @(negedge mclk_in);
    d = rdata_in;
  endtask
endmodule

// ---- tb/accel_event_monitor.sv ----
`timescale 1ns/1ps
module accel_event_monitor #(
  parameter int SAMPLE_W = 8
) (
  // Clock and reset
  input wire logic                mclk_in,
  input wire logic                resetn_in,
  // Register port
  input wire logic [6:0]          addr_in,
  input wire logic [7:0]          wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [7:0]          rdata_out,
  // Sensing chain and pad
  input wire logic [SAMPLE_W-1:0] x_value_in,
  input wire logic [SAMPLE_W-1:0] z_value_in,
  input wire logic [2:0]          sample_valid_in,
  input wire logic                event_pad_out
);
  logic [7:0] x_last_q;
  logic [7:0] z_last_q;
  logic [2:0] pad_sel_q;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      x_last_q <= 8'h00;
      z_last_q <= 8'h00;
      pad_sel_q <= 3'h0;
    end else begin
      if (sample_valid_in[0]) begin
        x_last_q <= x_value_in[SAMPLE_W-1 -: 8];
      end
      if (sample_valid_in[2]) begin
        z_last_q <= z_value_in[SAMPLE_W-1 -: 8];
      end
      if (wr_in && addr_in == 7'h22) begin
        pad_sel_q <= wdata_in[2:0];
      end
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_rd(a);
    rd_in && addr_in == a && sample_valid_in == 3'h0
      ##1 sample_valid_in == 3'h0;
  endsequence
  sequence s_wr_rd(a);
    wr_in && addr_in == a ##2 rd_in && addr_in == a;
  endsequence
  rb_cfg_a: assert property (
    s_wr_rd(7'h30) |=> rdata_out == $past(wdata_in, 3))
    else $error("event config readback differs");
  rb_pad_a: assert property (
    s_wr_rd(7'h22) |=> rdata_out == $past(wdata_in, 3))
    else $error("pad control readback differs");
  pad_gnd_a: assert property (
    (pad_sel_q == 3'h0) [*3] |-> !event_pad_out)
    else $error("pad not grounded");
  x_data_a: assert property (
    rd_in && addr_in == 7'h29 && !sample_valid_in[0]
      |=> rdata_out == x_last_q) else $error("x sample wrong");
  z_data_a: assert property (
    rd_in && addr_in == 7'h2d && !sample_valid_in[2]
      |=> rdata_out == z_last_q) else $error("z sample wrong");
  ovr_axis_a: assert property (
    rd_in && addr_in == 7'h27
      |=> (rdata_out[6:4] & ~rdata_out[2:0]) == 3'h0)
    else $error("axis overrun without new data");
  ovr_all_a: assert property (
    rd_in && addr_in == 7'h27 |=> !rdata_out[7] || rdata_out[3])
    else $error("combined overrun without new set");
  rd_clear_a: assert property (
    s_rd(7'h29) ##1 s_rd(7'h2b) ##1 s_rd(7'h2d) ##1 s_rd(7'h27)
      |-> rdata_out == 8'h00) else $error("flags not cleared");
endmodule
bind accel_event_regs accel_event_monitor #(.SAMPLE_W(SAMPLE_W))
  accel_event_monitor_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .x_value_in(x_value_in),
  .z_value_in(z_value_in), .sample_valid_in(sample_valid_in),
  .event_pad_out(event_pad_out));

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr_pulse;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] xv = 8'h00;
  logic [7:0] yv = 8'h00;
  logic [7:0] zv = 8'h00;
  logic [2:0] vld = 3'h0;
  logic       tick = 1'b0;
  logic       pad;
  int         bad_count = 0;
  int         n_checks = 0;
  initial begin
    forever #2 mclk = ~mclk;
  end
  accel_event_regs accel_event_regs_inst (.mclk_in(mclk),
    .resetn_in(resetn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_pulse),
    .rd_in(rd), .rdata_out(rdata), .x_value_in(xv), .y_value_in(yv),
    .z_value_in(zv), .sample_valid_in(vld), .period_tick_in(tick),
    .event_pad_out(pad));
  host_model host_model_inst (.mclk_in(mclk), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr_pulse), .rd_out(rd), .rdata_in(rdata));
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_model_inst.wr_reg(a, d);
  endtask
  task automatic chk(input logic [6:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] d;
    host_model_inst.rd_reg(a, d);
    n_checks++;
    if ((d & m) !== e) begin
      bad_count++;
      $display("MISMATCH reg %h expected %h seen %h", a, e, d & m);
    end
  endtask
  task automatic chk_pad(input logic e);
    int i;
    i = 0;
    while (pad !== e && i < 16) begin
      @(negedge mclk);
      i++;
    end
    n_checks++;
    if (pad !== e) begin
      bad_count++;
      $display("MISMATCH pad expected %b seen %b", e, pad);
      final_report();
    end
  endtask
  task automatic smp(input logic [2:0] v, input logic [7:0] x, y, z);
    @(posedge mclk);
    xv <= x;
    yv <= y;
    zv <= z;
    vld <= v;
    tick <= 1'b1;
    @(posedge mclk);
    vld <= 3'h0;
    tick <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_reset;
    chk(7'h20, 8'hff, 8'h07);
    chk(7'h22, 8'hff, 8'h00);
    chk(7'h27, 8'hff, 8'h00);
    chk(7'h30, 8'hff, 8'h00);
    chk(7'h31, 8'hff, 8'h00);
    chk(7'h32, 8'hff, 8'h02);
    chk(7'h28, 8'hff, 8'h00);
  endtask
  task automatic t_flags;
    wr(7'h22, 8'h04);
    smp(3'h7, 8'h80, 8'h7f, 8'hff);
    chk(7'h27, 8'hff, 8'h0f);
    chk_pad(1'b1);
    smp(3'h7, 8'h01, 8'h02, 8'h03);
    chk(7'h27, 8'hff, 8'hff);
    chk(7'h29, 8'hff, 8'h01);
    chk(7'h27, 8'hff, 8'hee);
    chk(7'h2b, 8'hff, 8'h02);
    chk(7'h2d, 8'hff, 8'h03);
    chk(7'h27, 8'hff, 8'h00);
    chk_pad(1'b0);
    wr(7'h22, 8'h84);
    chk(7'h22, 8'hff, 8'h84);
    chk_pad(1'b1);
    wr(7'h22, 8'h80);
    chk_pad(1'b0);
  endtask
  task automatic t_disable;
    wr(7'h20, 8'h06);
    smp(3'h7, 8'h10, 8'h20, 8'h30);
    chk(7'h27, 8'hff, 8'h0e);
    chk(7'h29, 8'hff, 8'h10);
    chk(7'h2b, 8'hff, 8'h20);
    chk(7'h2d, 8'hff, 8'h30);
    chk(7'h27, 8'hff, 8'h00);
    wr(7'h20, 8'h07);
  endtask
  task automatic t_or;
    wr(7'h32, 8'h10);
    wr(7'h30, 8'h03);
    chk(7'h30, 8'hff, 8'h03);
    wr(7'h22, 8'h01);
    smp(3'h1, 8'h20, 8'h00, 8'h00);
    chk_pad(1'b1);
    chk(7'h31, 8'h43, 8'h42);
    smp(3'h1, 8'h05, 8'h00, 8'h00);
    chk(7'h31, 8'h43, 8'h41);
  endtask
  task automatic t_and_latch;
    // Let the live source settle to idle before latching is switched on.
    wr(7'h30, 8'h00);
    wr(7'h30, 8'hca);
    smp(3'h3, 8'he0, 8'h05, 8'h00);
    chk(7'h31, 8'h40, 8'h00);
    smp(3'h3, 8'he0, 8'h30, 8'h00);
    chk_pad(1'b1);
    smp(3'h3, 8'h05, 8'h05, 8'h00);
    chk_pad(1'b1);
    chk(7'h31, 8'h4a, 8'h4a);
    chk_pad(1'b0);
    chk(7'h31, 8'h40, 8'h00);
  endtask
  task automatic t_duration;
    wr(7'h33, 8'h02);
    wr(7'h30, 8'h02);
    smp(3'h1, 8'h20, 8'h00, 8'h00);
    smp(3'h1, 8'h20, 8'h00, 8'h00);
    chk(7'h31, 8'h40, 8'h00);
    smp(3'h1, 8'h20, 8'h00, 8'h00);
    chk(7'h31, 8'h43, 8'h42);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_flags();
    t_disable();
    t_or();
    t_and_latch();
    t_duration();
    final_report();
  end
endmodule
